// file: logic/sbc_mode_status.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - mode field: sleep, stop, normal+clear, normal
// - after normal+clear, lower mode bit reads one
// - watchdog clear in normal request always accepted
// - sleep/stop only after second matching byte
// - bit7 high marks interrupt or wake source
// - bit6 reports bus wake or fault
// - bit5 overvoltage with hysteresis
// - bit4 supply undervoltage
// - bit3 regulator heat warning
// - bit2 switch overheat shutdown
// - bits1:0 wake inputs, first read gives source
// - one byte per transfer, msb first
// - status captured at chip select fall
// - slew pair 11 keeps slew unchanged
module sbc_mode_status
    import sbc_cmd_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic MOSI,
    output logic MISO,
    input wire logic BUS_WAKE,
    input wire logic BUS_FAULT,
    input wire logic SUPPLY_OVERVOLTAGE,
    input wire logic SUPPLY_UNDERVOLTAGE,
    input wire logic REGULATOR_HEAT,
    input wire logic SWITCH_OVERHEAT,
    input wire logic WAKE_INPUT_A,
    input wire logic WAKE_INPUT_B,
    input wire logic WAKE_EVENT,
    output logic [1:0] BUS_SLEW_SELECT,
    output logic BUS_PULLUP_DISCONNECT,
    output logic HIGH_SIDE_SWITCH_ONE,
    output logic HIGH_SIDE_SWITCH_TWO,
    output logic HIGH_SIDE_SWITCH_THREE,
    output logic [1:0] MODE_SELECT,
    output logic WATCHDOG_CLEAR,
    output logic [3:0] DEVICE_MODE
);
    // ------------------------------------------------------------
    // crossings
    // ------------------------------------------------------------
    logic cs_n_s;
    logic tog_s;
    logic rx_toggle;
    logic [7:0] rx_byte;
    logic tog_seen_q;
    logic ov_s, uv_s, bw_s, bf_s, rh_s, sh_s, wa_s, wb_s, we_s;

    sync3 u_sync_cs (.clk(REF_CLK), .rst(RST), .din(CS_N), .dout(cs_n_s));
    sync3 u_sync_tog (.clk(REF_CLK), .rst(RST), .din(rx_toggle), .dout(tog_s));
    sync3 u_sync_ov (.clk(REF_CLK), .rst(RST), .din(SUPPLY_OVERVOLTAGE), .dout(ov_s));
    sync3 u_sync_uv (.clk(REF_CLK), .rst(RST), .din(SUPPLY_UNDERVOLTAGE), .dout(uv_s));
    sync3 u_sync_bw (.clk(REF_CLK), .rst(RST), .din(BUS_WAKE), .dout(bw_s));
    sync3 u_sync_bf (.clk(REF_CLK), .rst(RST), .din(BUS_FAULT), .dout(bf_s));
    sync3 u_sync_rh (.clk(REF_CLK), .rst(RST), .din(REGULATOR_HEAT), .dout(rh_s));
    sync3 u_sync_sh (.clk(REF_CLK), .rst(RST), .din(SWITCH_OVERHEAT), .dout(sh_s));
    sync3 u_sync_wa (.clk(REF_CLK), .rst(RST), .din(WAKE_INPUT_A), .dout(wa_s));
    sync3 u_sync_wb (.clk(REF_CLK), .rst(RST), .din(WAKE_INPUT_B), .dout(wb_s));
    sync3 u_sync_we (.clk(REF_CLK), .rst(RST), .din(WAKE_EVENT), .dout(we_s));

    // status byte lives in the core domain and is held stable during a frame
    logic [7:0] status_q;

    spi_byte_link u_link (
        .sclk(SCLK),
        .cs_n(CS_N),
        .mosi(MOSI),
        .load_byte(status_q),
        .miso(MISO),
        .rx_byte(rx_byte),
        .rx_toggle(rx_toggle)
    );

    // ------------------------------------------------------------
    // frame edges and byte arrival
    // ------------------------------------------------------------
    logic cs_prev_q;
    wire cs_fall = cs_prev_q && !cs_n_s;
    wire byte_arrive = tog_s != tog_seen_q;
    // rx_byte stable since its toggle passed four flops
    wire [7:0] cmd = rx_byte;
    wire [1:0] cmd_mode = cmd[BIT_MODE_UPPER:BIT_MODE_LOWER];
    wire [1:0] cmd_slew = cmd[BIT_SLEW_UPPER:BIT_SLEW_LOWER];
    wire is_lp_cmd = ((cmd & LP_CMD_MASK) == LP_SLEEP_CMD) || ((cmd & LP_CMD_MASK) == LP_STOP_CMD);
    wire is_wdclr = cmd_mode == MODE_NORMAL_WDCLR;

    // ------------------------------------------------------------
    // write side
    // ------------------------------------------------------------
    logic pend_q;
    logic [7:0] pend_cmd_q;
    logic [7:0] ctrl_q;
    logic [1:0] slew_q;
    logic wdclr_q;
    dev_mode_t mode_q;
    dev_mode_t mode_d;
    logic lp_confirm;

    assign lp_confirm = byte_arrive && pend_q && is_lp_cmd
        && ((cmd & LP_CMD_MASK) == (pend_cmd_q & LP_CMD_MASK));

    // mode machine; wake events return sleep or stop to normal request
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            ST_NREQ, ST_NORMAL: begin
                if (lp_confirm) begin
                    mode_d = (cmd_mode == MODE_SLEEP) ? ST_SLEEP : ST_STOP;
                end else if (byte_arrive && mode_q == ST_NREQ && cmd_mode[1]) begin
                    mode_d = ST_NORMAL;
                end
            end
            ST_STOP, ST_SLEEP: begin
                if (we_s) begin
                    mode_d = ST_NREQ;
                end
            end
            default: mode_d = ST_NREQ;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tog_seen_q <= 1'b0;
            // matches the synchroniser's reset level, so release shows no false fall
            cs_prev_q <= 1'b0;
            pend_q <= 1'b0;
            pend_cmd_q <= 8'h00;
            ctrl_q <= CTRL_RESET;
            slew_q <= SLEW_RESET;
            wdclr_q <= 1'b0;
            mode_q <= ST_NREQ;
        end else begin
            tog_seen_q <= tog_s;
            cs_prev_q <= cs_n_s;
            mode_q <= mode_d;
            wdclr_q <= byte_arrive && is_wdclr;
            if (byte_arrive) begin
                // low-power bytes copy the pull-up bit and clear the high-side switches at once; mode bits wait until confirmed
                if (is_lp_cmd) begin
                    pend_q <= !pend_q || !lp_confirm;
                    pend_cmd_q <= cmd;
                    ctrl_q[BIT_PULLUP] <= cmd[BIT_PULLUP];
                    ctrl_q[BIT_HS3:BIT_HS1] <= 3'h0;
                    if (lp_confirm) begin
                        pend_q <= 1'b0;
                        ctrl_q[1:0] <= cmd_mode;
                    end
                end else begin
                    pend_q <= 1'b0;
                    ctrl_q[7:2] <= cmd[7:2];
                    ctrl_q[1:0] <= is_wdclr ? MODE_NORMAL : cmd_mode;
                    if (cmd_slew != SLEW_LOWPOWER) begin
                        slew_q <= cmd_slew;
                    end
                end
            end
        end
    end

    assign BUS_SLEW_SELECT = slew_q;
    assign BUS_PULLUP_DISCONNECT = ctrl_q[BIT_PULLUP];
    assign HIGH_SIDE_SWITCH_THREE = ctrl_q[BIT_HS3];
    assign HIGH_SIDE_SWITCH_TWO = ctrl_q[BIT_HS2];
    assign HIGH_SIDE_SWITCH_ONE = ctrl_q[BIT_HS1];
    assign MODE_SELECT = ctrl_q[1:0];
    assign WATCHDOG_CLEAR = wdclr_q;
    assign DEVICE_MODE = mode_q;

    // ------------------------------------------------------------
    // read side: latched wake source until the first read after wake
    // ------------------------------------------------------------
    logic wake_pend_q;
    logic src_bus_q, src_a_q, src_b_q;
    wire in_low_power = (mode_q == ST_SLEEP) || (mode_q == ST_STOP);
    wire [7:0] live_status = {1'b0, bw_s | bf_s, ov_s, uv_s, rh_s, sh_s, wb_s, wa_s};
    wire [7:0] src_status = {1'b1, src_bus_q, 3'h0, 1'b0, src_b_q, src_a_q};

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            wake_pend_q <= 1'b0;
            src_bus_q <= 1'b0;
            src_a_q <= 1'b0;
            src_b_q <= 1'b0;
            status_q <= 8'h00;
        end else begin
            if (in_low_power && we_s) begin
                wake_pend_q <= 1'b1;
                src_bus_q <= bw_s;
                src_a_q <= wa_s;
                src_b_q <= wb_s;
            end
            // capture on chip-select fall; comparator thresholds live in the analog front end
            if (cs_fall) begin
                status_q <= wake_pend_q ? src_status : live_status;
                if (!(in_low_power && we_s)) begin
                    wake_pend_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_wdclr_pulse;
        @(posedge REF_CLK) disable iff (RST)
        byte_arrive && is_wdclr |=> WATCHDOG_CLEAR && MODE_SELECT == MODE_NORMAL;
    endproperty
    a_wdclr_pulse: assert property (p_wdclr_pulse) else $error("watchdog clear not decoded");

    property p_no_single_lp;
        @(posedge REF_CLK) disable iff (RST)
        byte_arrive && is_lp_cmd && !pend_q |=> !in_low_power || $past(in_low_power);
    endproperty
    a_no_single_lp: assert property (p_no_single_lp) else $error("low power on single byte");

    property p_confirm_enters;
        @(posedge REF_CLK) disable iff (RST)
        lp_confirm && (cmd_mode == MODE_SLEEP) |=> mode_q == ST_SLEEP;
    endproperty
    a_confirm_enters: assert property (p_confirm_enters) else $error("sleep not entered");

    property p_slew_hold;
        @(posedge REF_CLK) disable iff (RST)
        byte_arrive && cmd_slew == SLEW_LOWPOWER |=> $stable(BUS_SLEW_SELECT);
    endproperty
    a_slew_hold: assert property (p_slew_hold) else $error("slew changed by low power pair");

    property p_pend_clear;
        @(posedge REF_CLK) disable iff (RST)
        byte_arrive && !is_lp_cmd |=> !pend_q;
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared");

    property p_capture;
        @(posedge REF_CLK) disable iff (RST)
        cs_fall && !wake_pend_q |=> status_q == $past(live_status) && !status_q[7];
    endproperty
    a_capture: assert property (p_capture) else $error("status not captured");

    property p_src_flag;
        @(posedge REF_CLK) disable iff (RST)
        cs_fall && wake_pend_q |=> status_q[7];
    endproperty
    a_src_flag: assert property (p_src_flag) else $error("source flag missing");

    property p_mismatch;
        @(posedge REF_CLK) disable iff (RST)
        byte_arrive && pend_q && !lp_confirm && !in_low_power |=> !in_low_power;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch entered low power");

    // clear pulse, normal request exit, stop entry, low-power controls and wake exit
    property p_wdclr_single;
        @(posedge REF_CLK) disable iff (RST)
        WATCHDOG_CLEAR |=> !WATCHDOG_CLEAR;
    endproperty
    a_wdclr_single: assert property (p_wdclr_single) else $error("watchdog clear longer than one cycle");

    property p_nreq_leaves;
        @(posedge REF_CLK) disable iff (RST)
        byte_arrive && mode_q == ST_NREQ && cmd_mode[1] |=> mode_q == ST_NORMAL;
    endproperty
    a_nreq_leaves: assert property (p_nreq_leaves) else $error("normal request not left");

    property p_stop_enters;
        @(posedge REF_CLK) disable iff (RST)
        lp_confirm && !in_low_power && (cmd_mode == MODE_STOP) |=> mode_q == ST_STOP;
    endproperty
    a_stop_enters: assert property (p_stop_enters) else $error("stop not entered");

    property p_lp_outputs;
        @(posedge REF_CLK) disable iff (RST)
        byte_arrive && is_lp_cmd |=> !HIGH_SIDE_SWITCH_ONE && !HIGH_SIDE_SWITCH_TWO && !HIGH_SIDE_SWITCH_THREE
            && BUS_PULLUP_DISCONNECT == $past(cmd[BIT_PULLUP]);
    endproperty
    a_lp_outputs: assert property (p_lp_outputs) else $error("low power byte controls wrong");

    property p_wake_exit;
        @(posedge REF_CLK) disable iff (RST)
        in_low_power && we_s |=> mode_q == ST_NREQ && wake_pend_q;
    endproperty
    a_wake_exit: assert property (p_wake_exit) else $error("wake did not latch source");

    c_sleep: cover property (@(posedge REF_CLK) disable iff (RST) mode_q == ST_NORMAL ##1 mode_q == ST_SLEEP);
    c_stop: cover property (@(posedge REF_CLK) disable iff (RST) mode_q == ST_NORMAL ##1 mode_q == ST_STOP);
    c_wake: cover property (@(posedge REF_CLK) disable iff (RST) cs_fall && wake_pend_q);
    c_wdclr: cover property (@(posedge REF_CLK) disable iff (RST) byte_arrive && is_wdclr);
endmodule
`default_nettype wire

// file: logic/spi_byte_link.sv
`timescale 1ns/1ps
`default_nettype none
// spi shifter on the serial clock (mode 0): msb first, one byte per frame
module spi_byte_link
    import sbc_cmd_pkg::*;
(
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic [7:0] load_byte,
    output logic miso,
    output logic [7:0] rx_byte,
    output logic rx_toggle
);
    logic [2:0] cnt_q;
    logic [6:0] sh_q;
    logic [7:0] tx_q;
    logic first_q;
    // power-up value stands in for a reset: this domain has none, and the core
    // only watches the toggle for changes, so its start level just has to be known
    logic tog_q = 1'b0;

    // ------------------------------------------------------------
    // receive; frame state restarts on cs high so no edge outside frames is needed
    // ------------------------------------------------------------
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= 3'h0;
            sh_q <= 7'h00;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            sh_q <= {sh_q[5:0], mosi};
        end
    end

    // completed byte handed over by toggle
    always_ff @(posedge sclk) begin
        if (!cs_n && cnt_q == BIT_CNT_LAST) begin
            rx_byte <= {sh_q, mosi};
            tog_q <= ~tog_q;
        end
    end

    // ------------------------------------------------------------
    // transmit: load_byte is held stable by the core throughout the frame
    // ------------------------------------------------------------
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            first_q <= 1'b1;
            tx_q <= 8'h00;
        end else begin
            first_q <= 1'b0;
            tx_q <= first_q ? {load_byte[6:0], 1'b0} : {tx_q[6:0], 1'b0};
        end
    end

    assign miso = first_q ? load_byte[7] : tx_q[7];

    assign rx_toggle = tog_q;
endmodule
`default_nettype wire

// file: logic/sync3.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; change counts once stages two and three agree
module sync3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

// file: shared/sbc_cmd_pkg.sv
`default_nettype none
package sbc_cmd_pkg;
    // ------------------------------------------------------------
    // write byte field positions
    // ------------------------------------------------------------
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned BIT_SLEW_UPPER = 7;
    localparam int unsigned BIT_SLEW_LOWER = 6;
    localparam int unsigned BIT_PULLUP = 5;
    localparam int unsigned BIT_HS3 = 4;
    localparam int unsigned BIT_HS2 = 3;
    localparam int unsigned BIT_HS1 = 2;
    localparam int unsigned BIT_MODE_UPPER = 1;
    localparam int unsigned BIT_MODE_LOWER = 0;
    // ------------------------------------------------------------
    // mode field codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_STOP = 2'h1;
    localparam logic [1:0] MODE_NORMAL_WDCLR = 2'h2;
    localparam logic [1:0] MODE_NORMAL = 2'h3;
    localparam logic [1:0] SLEW_LOWPOWER = 2'h3;
    // low-power command with pull-up bit masked
    localparam logic [7:0] LP_CMD_MASK = 8'hDF;
    localparam logic [7:0] LP_SLEEP_CMD = 8'hC0;
    localparam logic [7:0] LP_STOP_CMD = 8'hC1;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h03;
    localparam logic [1:0] SLEW_RESET = 2'h0;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    // normal request timeout, kept for reference of watchdog clear acceptance
    localparam int unsigned NREQ_TIMEOUT_MS = 150;
    localparam int unsigned CLK_HZ = 10000000;

    typedef enum logic [3:0] {
        ST_NREQ = 4'h1,
        ST_NORMAL = 4'h2,
        ST_STOP = 4'h4,
        ST_SLEEP = 4'h8
    } dev_mode_t;
endpackage
`default_nettype wire

// file: verification/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host side spi master, mode 0, 80 ns serial clock
// ------------------------------------------------------------
module spi_host_model (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    // serial clock stands low between frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // one whole byte per frame; the 700 ns lead lets the core capture status first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #37 cs_n = 1'b0;
        #700;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #40 sclk = 1'b1;
            rx[i] = miso;
            #40 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        mosi = ~mosi; // released line must not keep showing the last bit
    endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// self-checking bench for the mode and status block
// ------------------------------------------------------------
module testbench;
    import sbc_cmd_pkg::*;
    logic clk, rst, wake_ev, sclk, cs_n, mosi, miso, pull, hs1, hs2, hs3, wdc;
    logic [7:0] stat, rx, b;
    logic [1:0] slew, msel, exp_slew;
    logic [3:0] dmode;
    int fail_count = 0;
    int checks_done = 0;
    int wd_cnt = 0;
    int wd_exp = 0;
    logic [7:0] corner [4] = '{8'h02, 8'hFE, 8'hBF, 8'h7F};
    logic [7:0] pa [4] = '{8'hC0, 8'hC0, 8'hE1, 8'hC0};
    logic [7:0] pb [4] = '{8'hC3, 8'hC1, 8'hC1, 8'hE0};
    logic [3:0] pm [4] = '{ST_NORMAL, ST_NORMAL, ST_STOP, ST_SLEEP};

    sbc_mode_status sbc_mode_status_inst (
        .REF_CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi), .MISO(miso),
        .BUS_WAKE(stat[7]), .BUS_FAULT(stat[6]), .SUPPLY_OVERVOLTAGE(stat[5]),
        .SUPPLY_UNDERVOLTAGE(stat[4]), .REGULATOR_HEAT(stat[3]), .SWITCH_OVERHEAT(stat[2]),
        .WAKE_INPUT_A(stat[0]), .WAKE_INPUT_B(stat[1]), .WAKE_EVENT(wake_ev),
        .BUS_SLEW_SELECT(slew), .BUS_PULLUP_DISCONNECT(pull), .HIGH_SIDE_SWITCH_ONE(hs1),
        .HIGH_SIDE_SWITCH_TWO(hs2), .HIGH_SIDE_SWITCH_THREE(hs3), .MODE_SELECT(msel),
        .WATCHDOG_CLEAR(wdc), .DEVICE_MODE(dmode)
    );
    spi_host_model spi_host_model_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    // 10 MHz core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // counts clear pulses; a stuck-high pulse shows up as an excess count
    always @(negedge clk) begin
        if (wdc === 1'b1) begin
            wd_cnt <= wd_cnt + 1;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] flags(input logic [7:0] s);
        return {1'b0, s[7] | s[6], s[5:0]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        checks_done++;
        if (seen !== expd) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expd);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // bytes stay 2 us apart so the core has seen each one
    task automatic send(input logic [7:0] tx);
        spi_host_model_inst.xfer(tx, rx);
        repeat (20) @(negedge clk);
    endtask

    // new random flag levels, given time to pass the synchronisers
    task automatic new_stat;
        @(negedge clk);
        stat = 8'($urandom);
        repeat (10) @(negedge clk);
    endtask

    // a byte with the upper mode bit set, then every control output checked
    task automatic ctrl_ok(input logic [7:0] tx, input logic [7:0] exp_rx);
        if (tx[7:6] != SLEW_LOWPOWER) exp_slew = tx[7:6];
        if (tx[1:0] == MODE_NORMAL_WDCLR) wd_exp++;
        send(tx);
        check(rx, exp_rx);
        check({slew, pull, hs3, hs2, hs1, msel}, {exp_slew, tx[5:2], MODE_NORMAL});
        check({4'h0, dmode}, {4'h0, ST_NORMAL});
        check(8'(wd_cnt), 8'(wd_exp));
    endtask

    // wake request from a low-power mode, then the source read and a clear
    task automatic wake_back;
        @(negedge clk);
        stat = 8'($urandom);
        wake_ev = 1'b1;
        repeat (20) @(negedge clk);
        wake_ev = 1'b0;
        repeat (5) @(negedge clk);
        check({4'h0, dmode}, {4'h0, ST_NREQ});
        ctrl_ok(8'h02, {1'b1, stat[7], 4'h0, stat[1:0]});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h6a8762b9));
        rst = 1'b1;
        wake_ev = 1'b0;
        stat = 8'h00;
        exp_slew = 2'h0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        check({slew, pull, hs3, hs2, hs1, msel}, {2'h0, 4'h0, MODE_NORMAL});
        check({4'h0, dmode}, {4'h0, ST_NREQ});
        $display("test reset done");
        // corner bytes first, then random ones; first byte clears in normal request
        for (int i = 0; i < 28; i++) begin
            b = (i < 4) ? corner[i] : (8'($urandom) | 8'h02);
            new_stat;
            ctrl_ok(b, flags(stat));
        end
        $display("test write and read done");
        // low-power pairs: broken, mismatched, stop with pull-up bit differing, sleep
        for (int k = 0; k < 4; k++) begin
            send(pa[k]);
            check({2'h0, slew, pull, hs3, hs2, hs1}, {2'h0, exp_slew, pa[k][5], 3'h0});
            check({4'h0, dmode}, {4'h0, ST_NORMAL});
            send(pb[k]);
            check({4'h0, dmode}, {4'h0, pm[k]});
            if (pm[k] != ST_NORMAL) begin
                wake_back;
            end else begin
                new_stat;
                ctrl_ok(8'h03, flags(stat));
            end
        end
        $display("test low power done");
        close_out;
    end

    // cuts a hang short well past the expected run time
    initial begin
        #2000000;
        fail_count++;
        close_out;
    end
endmodule
`default_nettype wire
